// ### rtl/dma_channel_control_word_decode.sv
// One DMA channel: control word decode, source reads, arbitration and write-back.
//
// Overview of operation
// - Source protection bits drive HPROT[3:1] only on source reads.
// - HPROT[3] on source reads follows control bit 20, cacheable when high.
// - HPROT[2] on source reads follows control bit 19, bufferable when high.
// - HPROT[1] on source reads follows control bit 18, privileged when high.
// - Bits 17..14 give exponent R; two to the R transfers per arbitration.
// - Exponents ten to fifteen give 1024 transfers, so no mid-cycle rearbitration.
// - Bits 13..4 hold transfers minus one, giving 1 to 1024.
// - Remaining count minus one is written back before each rearbitration and at the end.
//
// Added by the designer: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_word_decode
  import dma_ctl_pkg::*;
#(
  parameter int FIFO_DEPTH = 8,
  parameter int DATA_W     = 32
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              srst,
  // Avalon-MM register slave.
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // Source read port toward the AHB manager.
  input  wire logic [31:0]       src_base,
  output logic                   src_valid,
  output src_req_t               src_req,
  input  wire logic              src_ready,
  input  wire logic              rdata_valid,
  input  wire logic [DATA_W-1:0] rdata,
  output logic                   rdata_ready,
  // Destination write port; carries no source protection.
  output logic                   dst_valid,
  output logic [DATA_W-1:0]      dst_data,
  output logic [3:0]             dst_hprot,
  input  wire logic              dst_ready,
  // Arbitration with other channels.
  output logic                   arb_request,
  input  wire logic              arb_grant
);
  typedef enum logic [2:0] {ST_IDLE, ST_ARB, ST_READ, ST_WAIT, ST_WRBACK} state_t;

  state_t             state_q;
  logic [31:0]        ctl_word;
  ctl_fields_t        fld;
  logic               start_pulse;
  logic               abort_pulse;
  logic [COUNT_W-1:0] remain_q;
  logic [COUNT_W-1:0] burst_q;
  logic [COUNT_W-1:0] ival_m1;
  logic               last_q;
  logic               wb_en;
  logic               done_q;
  logic [15:0]        total_q;
  logic [31:0]        addr_q;
  logic [2:0]         prot_q;
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic [DATA_W-1:0]  fifo_out_data;
  logic               src_fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Register slave.
  avmm_regs u_regs (
    .clk_sys         (clk_sys),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .ctl_word        (ctl_word),
    .start_pulse     (start_pulse),
    .abort_pulse     (abort_pulse),
    .wb_en           (wb_en),
    .wb_count        (remain_q),
    .status          ({done_q, state_q != ST_IDLE}),
    .xfer_total      (total_q)
  );

  // Field decode of the live control word.
  assign fld     = decode_ctl(ctl_word);
  assign ival_m1 = interval_m1(fld.rpow);

  ////////////////////////////////////////////////////////////////////////////////
  // Channel sequencer.
  assign arb_request = (state_q == ST_ARB);
  assign wb_en       = (state_q == ST_WRBACK);
  assign src_fire    = src_valid && src_ready;

  // State register; rearbitration entered after write-back of the remaining count.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (abort_pulse) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE:   if (start_pulse) state_q <= ST_ARB;
        ST_ARB:    if (arb_grant) state_q <= ST_READ;
        ST_READ:   if (src_fire) state_q <= ST_WAIT;
        ST_WAIT: begin
          if (rdata_valid && fifo_in_ready) begin
            // The last flag only settles on this edge, so test the count itself.
            if (remain_q == '0 || burst_q == ival_m1) begin
              state_q <= ST_WRBACK;
            end else begin
              state_q <= ST_READ;
            end
          end
        end
        ST_WRBACK: state_q <= last_q ? ST_IDLE : ST_ARB;
        default:   state_q <= ST_IDLE;
      endcase
    end
  end

  // Remaining count in minus-one form, and transfers since arbitration.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      remain_q <= '0;
      burst_q  <= '0;
      last_q   <= 1'b0;
    end else if (state_q == ST_IDLE && start_pulse) begin
      remain_q <= fld.n_minus_1;
      burst_q  <= '0;
      last_q   <= 1'b0;
    end else if (state_q == ST_ARB && arb_grant) begin
      burst_q <= '0;
    end else if (state_q == ST_WAIT && rdata_valid && fifo_in_ready) begin
      burst_q <= burst_q + 1'b1;
      if (remain_q == '0) begin
        last_q <= 1'b1;
      end else begin
        remain_q <= remain_q - 1'b1;
      end
    end
  end

  // Source address, protection latch, completion and total count.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_q  <= 32'h0000_0000;
      prot_q  <= 3'h0;
      done_q  <= 1'b0;
      total_q <= 16'h0000;
    end else begin
      if (state_q == ST_IDLE && start_pulse) begin
        addr_q  <= src_base;
        prot_q  <= fld.src_prot;
        done_q  <= 1'b0;
        total_q <= 16'h0000;
      end else if (src_fire) begin
        addr_q <= addr_q + 32'h0000_0004;
      end
      if (rdata_valid && rdata_ready) begin
        total_q <= total_q + 16'h0001;
      end
      if (state_q == ST_WRBACK && last_q) begin
        done_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Source read request; protection applies only here.
  assign src_valid        = (state_q == ST_READ);
  assign src_req.addr     = addr_q;
  assign src_req.hprot[3] = prot_q[2];
  assign src_req.hprot[2] = prot_q[1];
  assign src_req.hprot[1] = prot_q[0];
  assign src_req.hprot[0] = 1'b1;
  assign rdata_ready      = (state_q == ST_WAIT) && fifo_in_ready;

  // Destination writes use fixed protection, independent of the source field.
  assign dst_hprot = 4'h1;
  assign dst_valid = fifo_out_valid;
  assign dst_data  = fifo_out_data;

  // Data buffer between source reads and destination writes.
  data_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .srst      (srst),
    .in_valid  (rdata_valid && state_q == ST_WAIT),
    .in_ready  (fifo_in_ready),
    .in_data   (rdata),
    .out_valid (fifo_out_valid),
    .out_ready (dst_ready),
    .out_data  (fifo_out_data)
  );
endmodule : dma_channel_control_word_decode
`default_nettype wire

// ### rtl/dma_ctl_pkg.sv
// Package with register map, control word fields and shared types.
package dma_ctl_pkg;

  // Register byte offsets on the Avalon-MM slave.
  localparam logic [3:0] OFF_CONTROL_WORD = 4'h0;
  localparam logic [3:0] OFF_COMMAND      = 4'h4;
  localparam logic [3:0] OFF_STATUS       = 4'h8;
  localparam logic [3:0] OFF_XFER_COUNT   = 4'hC;

  // Control word field positions.
  localparam int SRC_PROT_HI = 20;
  localparam int SRC_PROT_LO = 18;
  localparam int RPOW_HI     = 17;
  localparam int RPOW_LO     = 14;
  localparam int COUNT_HI    = 13;
  localparam int COUNT_LO    = 4;

  // Widths and limits.
  localparam int COUNT_W = 10;
  localparam int RPOW_W  = 4;
  localparam logic [RPOW_W-1:0] RPOW_MAX = 4'hA;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

  // Command bits and status bits.
  localparam int CMD_START = 0;
  localparam int CMD_ABORT = 1;
  localparam int STS_BUSY  = 0;
  localparam int STS_DONE  = 1;

  // Fields decoded from the control word.
  typedef struct packed {
    logic [2:0]         src_prot;
    logic [RPOW_W-1:0]  rpow;
    logic [COUNT_W-1:0] n_minus_1;
  } ctl_fields_t;

  // Source read request carried to the AHB manager.
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  hprot;
  } src_req_t;

  // Decodes the fields out of a control word.
  function automatic ctl_fields_t decode_ctl(input logic [31:0] w);
    ctl_fields_t f;
    f.src_prot  = w[SRC_PROT_HI:SRC_PROT_LO];
    f.rpow      = w[RPOW_HI:RPOW_LO];
    f.n_minus_1 = w[COUNT_HI:COUNT_LO];
    return f;
  endfunction : decode_ctl

  // Interval minus one in transfers; exponents of ten or more give 1024.
  function automatic logic [COUNT_W-1:0] interval_m1(input logic [RPOW_W-1:0] r);
    logic [COUNT_W:0] v;
    v = 11'h001;
    if (r >= RPOW_MAX) begin
      v = 11'h400;
    end else begin
      v = 11'h001 << r;
    end
    return COUNT_W'(v - 11'h001);
  endfunction : interval_m1

endpackage : dma_ctl_pkg

// ### rtl/data_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
`default_nettype none
module data_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input  wire logic             clk_sys,
  input  wire logic             srst,
  // Fill side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  // Handshakes and honest full and empty.
  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_q];

  // Storage write.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : data_fifo
`default_nettype wire

// ### rtl/avmm_regs.sv
// Avalon-MM register slave for the channel control word and status.
`timescale 1ns/1ps
`default_nettype none
module avmm_regs
  import dma_ctl_pkg::*;
(
  // Clock and reset.
  input  wire logic               clk_sys,
  input  wire logic               srst,
  // Avalon-MM slave.
  input  wire logic [3:0]         avs_address,
  input  wire logic               avs_read,
  input  wire logic               avs_write,
  input  wire logic [31:0]        avs_writedata,
  input  wire logic [3:0]         avs_byteenable,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // Engine side.
  output logic [31:0]             ctl_word,
  output logic                    start_pulse,
  output logic                    abort_pulse,
  input  wire logic               wb_en,
  input  wire logic [COUNT_W-1:0] wb_count,
  input  wire logic [1:0]         status,
  input  wire logic [15:0]        xfer_total
);
  logic [31:0] ctl_q;
  logic        ack_q;
  logic [31:0] rdata_d;

  // One wait cycle: the answer comes on the second edge of the request.
  assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
  assign ctl_word        = ctl_q;
  assign start_pulse = avs_write && ack_q && avs_address == OFF_COMMAND
                       && avs_writedata[CMD_START];
  assign abort_pulse = avs_write && ack_q && avs_address == OFF_COMMAND
                       && avs_writedata[CMD_ABORT];

  // Acknowledge toggles so that each request is taken once.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read || avs_write) && !ack_q;
    end
  end

  // Control word; the engine's write-back wins over a software write.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_q <= CONTROL_RESET;
    end else begin
      if (avs_write && ack_q && avs_address == OFF_CONTROL_WORD) begin
        for (int b = 0; b < 4; b++) begin
          if (avs_byteenable[b]) begin
            ctl_q[b*8 +: 8] <= avs_writedata[b*8 +: 8];
          end
        end
      end
      if (wb_en) begin
        ctl_q[COUNT_HI:COUNT_LO] <= wb_count;
      end
    end
  end

  // Read mux; unmapped offsets read zero.
  always_comb begin
    case (avs_address)
      OFF_CONTROL_WORD: rdata_d = ctl_q;
      OFF_STATUS:       rdata_d = {30'h0000_0000, status};
      OFF_XFER_COUNT:   rdata_d = {16'h0000, xfer_total};
      default:          rdata_d = 32'h0000_0000;
    endcase
  end

  // Read data registered.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_q) begin
      avs_readdata <= rdata_d;
    end
  end
endmodule : avmm_regs
`default_nettype wire

// ### tb/dma_ctl_sva.sv
// Checker for the channel decode block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module dma_ctl_sva
  import dma_ctl_pkg::*;
(
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        srst,
  // Register bus.
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  // Data path and arbitration.
  input wire logic        src_valid,
  input wire src_req_t    src_req,
  input wire logic        src_ready,
  input wire logic        rdata_valid,
  input wire logic        rdata_ready,
  input wire logic        dst_valid,
  input wire logic [3:0]  dst_hprot,
  input wire logic        arb_request,
  input wire logic        arb_grant
);
  logic [31:0] ctl_q;
  logic [10:0] xc_q;
  logic [10:0] tot_q;
  logic [10:0] ivl;
  logic        start;
  logic        hs;
  // Accepted start command and accepted source read.
  assign start = avs_write && !avs_waitrequest && avs_address == 4'h4 && avs_writedata[0];
  assign hs    = src_valid && src_ready;
  // Shadow of the control word as software last wrote it.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ctl_q <= 32'h0000_0000;
    end else if (avs_write && !avs_waitrequest && avs_address == 4'h0) begin
      ctl_q <= avs_writedata;
    end
  end
  // Interval in transfers; exponents of ten and up saturate.
  assign ivl = (ctl_q[17:14] >= 4'hA) ? 11'h400 : (11'h001 << ctl_q[17:14]);
  // Transfers since the last grant.
  always_ff @(posedge clk_sys) begin
    if (srst || start || (arb_request && arb_grant)) begin
      xc_q <= 11'h000;
    end else if (hs) begin
      xc_q <= xc_q + 11'h001;
    end
  end
  // Transfers since the start command.
  always_ff @(posedge clk_sys) begin
    if (srst || start) begin
      tot_q <= 11'h000;
    end else if (hs) begin
      tot_q <= tot_q + 11'h001;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  AST_SRC_PROT: assert property (src_valid |-> src_req.hprot == {ctl_q[20:18], 1'b1})
    else $error("source protection bits wrong");
  AST_DST_PROT: assert property (dst_valid |-> dst_hprot == 4'h1)
    else $error("destination write carries source protection");
  AST_SRC_HOLD: assert property (src_valid && !src_ready |=> src_valid && $stable(src_req))
    else $error("source request changed before acceptance");
  AST_RUN_LEN: assert property (hs |-> xc_q < ivl)
    else $error("too many transfers without arbitration");
  AST_ARB_POINT: assert property ($rose(arb_request) |-> xc_q == 11'h000 || xc_q == ivl)
    else $error("arbitration entered at wrong count");
  AST_ARB_HOLD: assert property (arb_request && !arb_grant |=> arb_request)
    else $error("arbitration request dropped without grant");
  AST_TOTAL: assert property (hs |-> tot_q <= {1'b0, ctl_q[13:4]})
    else $error("more transfers than programmed");
  AST_ONE_RD: assert property (rdata_ready |-> !src_valid)
    else $error("second read issued while one outstanding");
  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("register access not answered after one wait cycle");
  AST_BUS_IDLE: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high without a request");
  // Main scenarios reached.
  cover property (arb_request && !arb_grant);
  cover property (rdata_valid && !rdata_ready);
  cover property (hs && xc_q == ivl - 11'h001);
endmodule : dma_ctl_sva
bind dma_channel_control_word_decode dma_ctl_sva chk_u (.clk_sys, .srst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .src_valid, .src_req, .src_ready,
  .rdata_valid, .rdata_ready, .dst_valid, .dst_hprot, .arb_request, .arb_grant);
`default_nettype wire

// ### tb/ahb_slave_model.sv
// Memory slave model answering source reads and taking destination writes.
`timescale 1ns/1ps
`default_nettype none
module ahb_slave_model
  import dma_ctl_pkg::*;
(
  // Clock and reset.
  input wire logic         clk_sys,
  input wire logic         srst,
  // Source reads and destination writes.
  input wire logic         src_valid,
  input wire src_req_t     src_req,
  output logic             src_ready,
  output logic             rdata_valid,
  output logic [31:0]      rdata,
  input wire logic         rdata_ready,
  output logic             dst_ready
);
  logic [7:0]  cnt_q = 8'h00;
  logic [31:0] addr_q;
  logic        pend_q;
  // Varying delays; long write stalls fill the buffer, released data flips.
  always_ff @(posedge clk_sys) begin
    cnt_q     <= cnt_q + 8'h01;
    dst_ready <= (cnt_q[7:6] != 2'b00);
    if (srst) begin
      src_ready   <= 1'b0;
      rdata_valid <= 1'b0;
      pend_q      <= 1'b0;
      rdata       <= 32'h0000_0000;
    end else begin
      src_ready <= src_valid && !src_ready && cnt_q[0];
      if (src_valid && src_ready) begin
        addr_q <= src_req.addr;
        pend_q <= 1'b1;
      end
      if (pend_q && !rdata_valid && cnt_q[1]) begin
        rdata_valid <= 1'b1;
        rdata       <= {addr_q[15:0], ~addr_q[15:0]};
        pend_q      <= 1'b0;
      end
      if (rdata_valid && rdata_ready) begin
        rdata_valid <= 1'b0;
        rdata       <= ~rdata;
      end
    end
  end
endmodule : ahb_slave_model
`default_nettype wire

// ### tb/test_dma_channel_control_word_decode.sv
// Self-checking bench for the channel decode block.
`timescale 1ns/1ps
`default_nettype none
module test_dma_channel_control_word_decode
  import dma_ctl_pkg::*;
;
  logic        clk_sys, srst, avs_read, avs_write, arb_grant, arb_d;
  logic [3:0]  avs_address, avs_byteenable, dst_hprot;
  logic [31:0] avs_writedata, avs_readdata, src_base, rdata, dst_data, q, ea;
  logic        avs_waitrequest, src_valid, src_ready, rdata_valid, rdata_ready;
  logic        dst_valid, dst_ready, arb_request;
  src_req_t    src_req;
  int          failures = 0, checks = 0, arbs = 0, didx = 0;

  dma_channel_control_word_decode dut_u (.clk_sys, .srst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .src_base, .src_valid, .src_req, .src_ready, .rdata_valid, .rdata, .rdata_ready,
    .dst_valid, .dst_data, .dst_hprot, .dst_ready, .arb_request, .arb_grant);
  ahb_slave_model slv_u (.clk_sys, .srst, .src_valid, .src_req, .src_ready,
    .rdata_valid, .rdata, .rdata_ready, .dst_ready);

  // Clock at 25 MHz.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic report_and_stop();
    if (failures == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tmo();
    failures++;
    report_and_stop();
  endtask : tmo

  // One register access, held until waitrequest is seen low.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address    <= a;
    avs_write      <= w;
    avs_read       <= !w;
    avs_writedata  <= d;
    avs_byteenable <= be;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) tmo();
    q = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  // Counts arbitration entries and checks every word delivered.
  always @(posedge clk_sys) begin
    if (arb_request === 1'b1 && !arb_d) arbs++;
    arb_d <= (arb_request === 1'b1);
    if (dst_valid === 1'b1 && dst_ready === 1'b1) begin
      ea = src_base + 32'(didx) * 4;
      chk(dst_data, {ea[15:0], ~ea[15:0]});
      didx++;
    end
  end

  // One whole cycle with exponent r, nt transfers and protection p.
  task automatic run(input int r, input int nt, input logic [2:0] p);
    int ivl, e, k, i;
    ivl = (r >= 10) ? 1024 : (1 << r);
    e = 1 + (nt - 1) / ivl;
    arbs = 0;
    didx = 0;
    bus(1'b1, 4'h0, {11'h000, p, r[3:0], 10'(nt - 1), 4'h0}, 4'hF);
    bus(1'b1, 4'h4, 32'h0000_0001, 4'hF);
    for (k = 0; k < e; k++) begin
      for (i = 0; i < 20000 && arb_request !== 1'b1; i++) @(posedge clk_sys);
      if (i >= 20000) tmo();
      if (k > 0) begin
        bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
        chk(q[13:4], 32'(nt - k * ivl - 1));
      end
      arb_grant <= 1'b1;
      @(posedge clk_sys);
      arb_grant <= 1'b0;
      @(posedge clk_sys);
    end
    for (i = 0; i < 2000 && (q[1] !== 1'b1 || didx < nt); i++) bus(1'b0, 4'h8, 32'h0, 4'hF);
    chk(q[1:0], 32'h2);
    chk(didx, nt);
    chk(arbs, e);
    bus(1'b0, 4'h0, 32'h0000_0000, 4'hF);
    chk(q, {11'h000, p, r[3:0], 14'h0000});
    bus(1'b0, 4'hC, 32'h0000_0000, 4'hF);
    chk(q[15:0], nt);
  endtask : run

  ////////////////////////////////////////////////////////////////////////
  // Reset, register checks, then cycles over exponents and counts.
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    arb_grant = 1'b0;
    arb_d = 1'b0;
    src_base = 32'h0000_1000;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk(q, CONTROL_RESET);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF, 4'h2);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    chk(q, 32'h0000_FF00);
    bus(1'b0, 4'h2, 32'h0, 4'hF);
    chk(q, 32'h0000_0000);
    run(0, 6, 3'h4);
    run(1, 6, 3'h2);
    run(2, 6, 3'h1);
    run(10, 6, 3'h5);
    run(15, 6, 3'h7);
    run(1, 1, 3'h0);
    run(9, 1024, 3'h3);
    report_and_stop();
  end
endmodule : test_dma_channel_control_word_decode
`default_nettype wire
